// ==== sync_fifo_9bit.v ====
// Purpose: Nine-bit first-in first-out buffer with separate write and read clocks,
//   programmable almost-empty and almost-full thresholds and a status slave.
// Assumes: clk_sys is the write clock; read_clock is a free-running, unrelated clock.
// Notes: resetn is synchronous active low and is re-synchronised into the read domain.
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`include "sync_fifo_map.vh"

module sync_fifo_9bit #(
  parameter DEPTH = `FIFO_DEPTH_DEF,
  parameter ADDR_W = `FIFO_ADDR_W_DEF
) (
  input wire clk_sys,
  input wire resetn,
  input wire read_clock,
  input wire [`FIFO_DATA_W-1:0] write_data_in,
  input wire write_enable_low_active,
  input wire write_enable_high_or_offset_load,
  input wire read_enable_a_n,
  input wire read_enable_b_n,
  input wire output_enable_n,
  output reg [`FIFO_DATA_W-1:0] read_data_out,
  output reg read_data_oe,
  output reg empty_flag_n,
  output reg almost_empty_flag_n,
  output reg full_flag_n,
  output reg almost_full_flag_n,
  input wire [`BUS_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);

  function [ADDR_W:0] gray_to_bin;
    input [ADDR_W:0] g;
    integer i;
    begin
      gray_to_bin[ADDR_W] = g[ADDR_W];
      for (i = ADDR_W - 1; i >= 0; i = i - 1) begin
        gray_to_bin[i] = gray_to_bin[i+1] ^ g[i];
      end
    end
  endfunction

  // ==================================================================
  // Storage
  // Plain dual-ported array: write port on clk_sys, read port on read_clock.
  reg [`FIFO_DATA_W-1:0] mem [0:DEPTH-1];

  // ==================================================================
  // Write domain (clk_sys)
  reg prog_mode_q;
  reg [ADDR_W:0] wbin_q;
  reg [ADDR_W:0] wgray_q;
  // Read pointer in Gray code; owned by the read side, sampled here.
  reg [ADDR_W:0] rgray_r_q;
  reg [ADDR_W:0] rgray_s1_q;
  reg [ADDR_W:0] rgray_s2_q;
  reg [`OFS_BYTE_W-1:0] ofs_q [0:3];
  reg [1:0] wsel_q;
  reg write_block_q;
  reg empty_s1_q;
  reg empty_s2_q;
  wire fifo_wr;
  wire ofs_wr;
  wire [ADDR_W:0] wbin_d;
  wire [ADDR_W:0] rbin_w;
  wire [ADDR_W:0] wcount;
  wire [ADDR_W:0] wfree;
  wire [15:0] full_ofs;
  wire [15:0] empty_ofs;
  wire bus_take;

  // Programmable-flag mode turns a low dual-purpose input into the load select.
  assign fifo_wr = ~write_enable_low_active & write_enable_high_or_offset_load
                   & full_flag_n & ~write_block_q;
  assign ofs_wr = prog_mode_q & ~write_enable_low_active
                  & ~write_enable_high_or_offset_load;
  assign wbin_d = wbin_q + {{ADDR_W{1'b0}}, fifo_wr};
  assign rbin_w = gray_to_bin(rgray_s2_q);
  assign wcount = wbin_d - rbin_w;
  assign wfree = DEPTH[ADDR_W:0] - wcount;
  assign empty_ofs = {ofs_q[1], ofs_q[0]};
  assign full_ofs = {ofs_q[3], ofs_q[2]};
  assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;

  // ==================================================================
  // Write-side synchronisers
  // Only the second stage of each pair is read, by the flag logic or the status slave, so a
  // metastable first stage has a whole write cycle to settle.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      rgray_s1_q <= {(ADDR_W+1){1'b0}};
      rgray_s2_q <= {(ADDR_W+1){1'b0}};
      // The buffer is empty after reset, so the status copy starts low as well.
      empty_s1_q <= 1'b0;
      empty_s2_q <= 1'b0;
    end else begin
      rgray_s1_q <= rgray_r_q;
      rgray_s2_q <= rgray_s1_q;
      empty_s1_q <= empty_flag_n;
      empty_s2_q <= empty_s1_q;
    end
  end

  // ==================================================================
  // Write pointer, offset registers and write-side flags
  // The full flag sees reads only through the synchronised pointer, so it
  // clears a few cycles late; that only costs throughput, never data.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      // The strap is re-sampled on every reset cycle, so the last one before release wins.
      prog_mode_q <= ~write_enable_high_or_offset_load;
      wbin_q <= {(ADDR_W+1){1'b0}};
      wgray_q <= {(ADDR_W+1){1'b0}};
      wsel_q <= `OFS_EMPTY_LSB;
      ofs_q[0] <= `OFS_LSB_RESET;
      ofs_q[1] <= `OFS_MSB_RESET;
      ofs_q[2] <= `OFS_LSB_RESET;
      ofs_q[3] <= `OFS_MSB_RESET;
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
      write_block_q <= 1'b0;
    end else begin
      if (fifo_wr) begin
        mem[wbin_q[ADDR_W-1:0]] <= write_data_in;
      end
      wbin_q <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
      if (ofs_wr) begin
        ofs_q[wsel_q] <= write_data_in[`OFS_BYTE_W-1:0];
        wsel_q <= wsel_q + 2'd1;
      end
      full_flag_n <= ~(wcount == DEPTH[ADDR_W:0]);
      almost_full_flag_n <= ~({{(15-ADDR_W){1'b0}}, wfree} <= full_ofs);
      if (avs_write && bus_take && avs_address == `REG_CTRL) begin
        write_block_q <= avs_writedata[`CTRL_WRITE_BLOCK_BIT];
      end
    end
  end

  // ==================================================================
  // Avalon-MM status slave
  // Every access costs one wait cycle, which keeps the read mux off the bus timing path.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `REG_STATUS: avs_readdata <= {28'h000_0000, prog_mode_q, empty_s2_q,
                                        almost_full_flag_n, full_flag_n};
          `REG_CTRL: avs_readdata <= {31'h0000_0000, write_block_q};
          `REG_OFFSETS: avs_readdata <= {full_ofs, empty_ofs};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==================================================================
  // Read domain (read_clock)
  reg rrst_s1_q;
  reg rrst_s2_q;
  reg mode_s1_q;
  reg mode_s2_q;
  reg ld_s1_q;
  reg ld_s2_q;
  reg [31:0] ofs_s1_q;
  reg [31:0] ofs_s2_q;
  reg [ADDR_W:0] wgray_s1_q;
  reg [ADDR_W:0] wgray_s2_q;
  reg [ADDR_W:0] rbin_q;
  reg oe_s1_q;
  reg oe_s2_q;
  reg [1:0] rsel_q;
  wire rd_req;
  wire ofs_rd;
  wire fifo_rd;
  wire [ADDR_W:0] rbin_d;
  wire [ADDR_W:0] wbin_r;
  wire [ADDR_W:0] rcount;
  reg [`OFS_BYTE_W-1:0] ofs_byte;

  assign rd_req = ~read_enable_a_n & ~read_enable_b_n;
  assign ofs_rd = rd_req & mode_s2_q & ~ld_s2_q;
  assign fifo_rd = rd_req & ~ofs_rd & empty_flag_n;
  assign rbin_d = rbin_q + {{ADDR_W{1'b0}}, fifo_rd};
  assign wbin_r = gray_to_bin(wgray_s2_q);
  assign rcount = wbin_r - rbin_d;

  always @* begin
    case (rsel_q)
      `OFS_EMPTY_LSB: ofs_byte = ofs_s2_q[7:0];
      `OFS_EMPTY_MSB: ofs_byte = ofs_s2_q[15:8];
      `OFS_FULL_LSB: ofs_byte = ofs_s2_q[23:16];
      default: ofs_byte = ofs_s2_q[31:24];
    endcase
  end

  // ==================================================================
  // Read-side reset synchroniser
  // resetn is released on clk_sys, so the read side needs its own copy of it.
  always @(posedge read_clock) begin
    rrst_s1_q <= resetn;
    rrst_s2_q <= rrst_s1_q;
  end

  // ==================================================================
  // Read-side synchronisers
  // Offsets only change while the load line is low, the same state in which reads of them are allowed; a
  // plain two-stage copy is used for these quasi-static words.
  always @(posedge read_clock) begin
    if (!rrst_s2_q) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
      ofs_s1_q <= {`OFS_MSB_RESET, `OFS_LSB_RESET, `OFS_MSB_RESET, `OFS_LSB_RESET};
      ofs_s2_q <= {`OFS_MSB_RESET, `OFS_LSB_RESET, `OFS_MSB_RESET, `OFS_LSB_RESET};
      wgray_s1_q <= {(ADDR_W+1){1'b0}};
      wgray_s2_q <= {(ADDR_W+1){1'b0}};
      oe_s1_q <= 1'b1;
      oe_s2_q <= 1'b1;
    end else begin
      mode_s1_q <= prog_mode_q;
      mode_s2_q <= mode_s1_q;
      ld_s1_q <= write_enable_high_or_offset_load;
      ld_s2_q <= ld_s1_q;
      ofs_s1_q <= {ofs_q[3], ofs_q[2], ofs_q[1], ofs_q[0]};
      ofs_s2_q <= ofs_s1_q;
      wgray_s1_q <= wgray_q;
      wgray_s2_q <= wgray_s1_q;
      // The output enable is a pin with no clock of its own, so it is settled here first.
      oe_s1_q <= output_enable_n;
      oe_s2_q <= oe_s1_q;
    end
  end

  // ==================================================================
  // Read pointer, output register and read-side flags
  // The empty flag uses this side's own pointer at once, so a read can never
  // run past the last stored word; only new writes are seen late.
  always @(posedge read_clock) begin
    if (!rrst_s2_q) begin
      rbin_q <= {(ADDR_W+1){1'b0}};
      rgray_r_q <= {(ADDR_W+1){1'b0}};
      rsel_q <= `OFS_EMPTY_LSB;
      read_data_out <= {`FIFO_DATA_W{1'b0}};
      read_data_oe <= 1'b0;
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else begin
      rbin_q <= rbin_d;
      rgray_r_q <= rbin_d ^ (rbin_d >> 1);
      // Outputs follow the enable three read edges late; bus turn-around must allow it.
      read_data_oe <= ~oe_s2_q;
      if (fifo_rd) begin
        read_data_out <= mem[rbin_q[ADDR_W-1:0]];
      end else if (ofs_rd) begin
        read_data_out <= {1'b0, ofs_byte};
        rsel_q <= rsel_q + 2'd1;
      end
      empty_flag_n <= ~(rcount == {(ADDR_W+1){1'b0}});
      almost_empty_flag_n <= ~({{(15-ADDR_W){1'b0}}, rcount} <= ofs_s2_q[15:0]);
    end
  end

endmodule // sync_fifo_9bit

// ==== sync_fifo_map.vh ====
// Purpose: Constants for the nine-bit dual-clock buffer and its status slave.
// Assumes: Included by the design and by the bench; definitions only.
// Notes: Byte addresses on the Avalon-MM slave; each register one aligned word.
`ifndef SYNC_FIFO_MAP_VH
`define SYNC_FIFO_MAP_VH

// ==================================================================
// Data and storage
`define FIFO_DATA_W 9
`define FIFO_DEPTH_DEF 256
`define FIFO_ADDR_W_DEF 8

// ==================================================================
// Offset registers
`define OFS_BYTE_W 8
`define OFS_EMPTY_LSB 2'd0
`define OFS_EMPTY_MSB 2'd1
`define OFS_FULL_LSB 2'd2
`define OFS_FULL_MSB 2'd3
`define OFS_LSB_RESET 8'h07
`define OFS_MSB_RESET 8'h00

// ==================================================================
// Avalon-MM register map
`define BUS_ADDR_W 4
`define REG_STATUS 4'h0
`define REG_CTRL 4'h4
`define REG_OFFSETS 4'h8
`define STAT_FULL_N_BIT 0
`define STAT_ALMOST_FULL_N_BIT 1
`define STAT_EMPTY_N_BIT 2
`define STAT_PROG_MODE_BIT 3
`define CTRL_WRITE_BLOCK_BIT 0

`endif

// ==== sync_fifo_9bit_assertions.sv ====
// Purpose: Port-level checks for the nine-bit dual-clock buffer.
// Assumes: Bound to sync_fifo_9bit; resetn reaches the read side late.
// Notes: Read-side checks wait four read edges after reset release.
module sync_fifo_9bit_assertions (
  input logic clk_sys,
  input logic resetn,
  input logic read_clock,
  input logic write_enable_high_or_offset_load,
  input logic read_enable_a_n,
  input logic read_enable_b_n,
  input logic output_enable_n,
  input logic [8:0] read_data_out,
  input logic read_data_oe,
  input logic empty_flag_n,
  input logic almost_empty_flag_n,
  input logic full_flag_n,
  input logic almost_full_flag_n,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // The read side leaves reset late, so its checks stay off until this copy settles.
  logic [3:0] sync_q = 4'h0;
  wire rdis = !resetn || !(&sync_q);
  always @(posedge read_clock) sync_q <= {sync_q[2:0], resetn};
  property p_bus; @(posedge clk_sys) disable iff (!resetn)
    $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  property p_wr_rst; @(posedge clk_sys) disable iff (!resetn)
    $rose(resetn) |-> full_flag_n && almost_full_flag_n && avs_waitrequest; endproperty
  a_wr_rst: assert property (p_wr_rst) else $error("write flags after reset");
  property p_rd_rst; @(posedge read_clock) disable iff (!resetn)
    $rose(&sync_q) |-> !empty_flag_n && !almost_empty_flag_n && read_data_out == 9'h000; endproperty
  a_rd_rst: assert property (p_rd_rst) else $error("read side after reset");
  property p_full; @(posedge clk_sys) disable iff (!resetn)
    !full_flag_n |-> !almost_full_flag_n; endproperty
  a_full: assert property (p_full) else $error("full without almost full");
  property p_empty; @(posedge read_clock) disable iff (rdis)
    !empty_flag_n |-> !almost_empty_flag_n; endproperty
  a_empty: assert property (p_empty) else $error("empty without almost empty");
  property p_oe_on; @(posedge read_clock) disable iff (rdis)
    !$past(output_enable_n, 3) |-> read_data_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
  property p_oe_off; @(posedge read_clock) disable iff (rdis)
    $past(output_enable_n, 3) |-> !read_data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs not released");
  property p_hold; @(posedge read_clock) disable iff (rdis)
    !empty_flag_n && !read_enable_a_n && !read_enable_b_n && write_enable_high_or_offset_load
    && $past(write_enable_high_or_offset_load, 2) |=> $stable(read_data_out); endproperty
  a_hold: assert property (p_hold) else $error("output moved while empty");
  c_full: cover property (@(posedge clk_sys) !full_flag_n);
  c_ofs: cover property (@(posedge read_clock) !read_enable_b_n && !write_enable_high_or_offset_load);
  c_wr: cover property (@(posedge clk_sys) avs_write && !avs_waitrequest);
endmodule // sync_fifo_9bit_assertions
bind sync_fifo_9bit sync_fifo_9bit_assertions sync_fifo_9bit_assertions_inst (.*);

// ==== fifo_reader_model.sv ====
// Purpose: Reader logic standing at the far side of the buffer.
// Assumes: Its read clock runs free, unrelated in phase to clk_sys.
// Notes: Stalls every other cycle by holding a single enable high.
module fifo_reader_model (
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic [8:0] read_data_out,
  output logic read_clock,
  output logic read_enable_a_n,
  output logic read_enable_b_n,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got[$];
  logic go_q = 1'b0, take_q = 1'b0, tick_q = 1'b0;
  int left = 0;
  initial begin
    read_clock = 1'b0;
    #13;
    forever #35 read_clock = ~read_clock;
  end
  // A word lands at the taking edge, so it is captured one edge later.
  always @(posedge read_clock) begin
    if (take_q)
      got.push_back(read_data_out);
    take_q <= !read_enable_a_n && !read_enable_b_n;
    tick_q <= ~tick_q;
    read_enable_a_n <= !(left > 0);
    read_enable_b_n <= !(left > 0 && tick_q);
    go_q <= go;
    if (go != go_q)
      left <= n;
    else if (left > 0 && tick_q)
      left <= left - 1;
  end
  assign busy = left != 0 || go != go_q || !read_enable_b_n || take_q;
endmodule // fifo_reader_model

// ==== dual_clock_sync_fifo_9bit_tb_top.sv ====
// Purpose: Self-checking bench for the nine-bit dual-clock buffer.
// Assumes: Programmable-flag strap; depth cut to 64 for a short run.
// Notes: The reader model owns the read clock and read enables.
`include "sync_fifo_map.vh"
module dual_clock_sync_fifo_9bit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, we_n = 1'b1, we_hi = 1'b0, oe_n = 1'b1, go = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, oe, ef_n, aef_n, ff_n, aff_n, wait_r, rclk, ra_n, rb_n;
  logic busy;
  logic [7:0] n = 8'h00;
  logic [8:0] din = 9'h000, rdata;
  logic [8:0] ld[5] = '{9'h105, 9'h000, 9'h008, 9'h000, 9'h003};
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  int bad_count = 0, comparisons = 0;
  initial forever #50 clk_sys = ~clk_sys;
  sync_fifo_9bit #(.DEPTH(64), .ADDR_W(6)) sync_fifo_9bit_inst (.clk_sys(clk_sys),
    .resetn(resetn), .read_clock(rclk), .write_data_in(din), .write_enable_low_active(we_n),
    .write_enable_high_or_offset_load(we_hi), .read_enable_a_n(ra_n), .read_enable_b_n(rb_n),
    .output_enable_n(oe_n), .read_data_out(rdata), .read_data_oe(oe), .empty_flag_n(ef_n),
    .almost_empty_flag_n(aef_n), .full_flag_n(ff_n), .almost_full_flag_n(aff_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(wait_r));
  fifo_reader_model fifo_reader_model_inst (.go(go), .n(n), .read_data_out(rdata),
    .read_clock(rclk), .read_enable_a_n(ra_n), .read_enable_b_n(rb_n), .busy(busy));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("mismatches %0d of %0d compares", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (wait_r !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task put(input int cnt, input logic [8:0] base, input logic hi);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_sys);
      we_n <= 1'b0;
      we_hi <= hi;
      din <= base + 9'(i);
    end
    @(posedge clk_sys);
    we_n <= 1'b1;
    we_hi <= 1'b1;
    @(negedge clk_sys);
  endtask
  task pop(input logic [7:0] cnt);
    fifo_reader_model_inst.got.delete();
    @(posedge clk_sys);
    n <= cnt;
    go <= !go;
    repeat (2) @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
  endtask
  // ==================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(q, 32'h0000000b);
    bus(1'b0, `REG_OFFSETS, 32'h0);
    chk(q, 32'h00070007);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h1);
    bus(1'b0, `REG_CTRL, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, `REG_CTRL, 32'h0);
    oe_n <= 1'b0;
    pop(8'd4);
    for (int i = 0; i < 4; i++) chk(fifo_reader_model_inst.got[i], i[0] ? 32'h0 : 32'h7);
    chk(oe, 1'b1);
    foreach (ld[i]) put(1, ld[i], 1'b0);
    bus(1'b0, `REG_OFFSETS, 32'h0);
    chk(q, 32'h00080003);
    put(3, 9'h100, 1'b1);
    repeat (8) @(negedge clk_sys);
    chk({ef_n, aef_n}, 2'b10);
    put(1, 9'h103, 1'b1);
    repeat (8) @(negedge clk_sys);
    chk(aef_n, 1'b1);
    put(51, 9'h104, 1'b1);
    chk({ff_n, aff_n}, 2'b11);
    put(1, 9'h137, 1'b1);
    chk({ff_n, aff_n}, 2'b10);
    put(8, 9'h138, 1'b1);
    chk(ff_n, 1'b0);
    put(1, 9'h0aa, 1'b1);
    pop(8'd66);
    for (int k = 0; k < 66; k++) chk(fifo_reader_model_inst.got[k], 32'h100 + (k < 64 ? k : 63));
    repeat (4) @(negedge clk_sys);
    chk({ef_n, aef_n}, 2'b00);
    @(posedge clk_sys);
    oe_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(oe, 1'b0);
    wrap_up;
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up;
  end
endmodule // dual_clock_sync_fifo_9bit_tb_top
